// file: design/vcr0_cfg.svh
// Offsets, field positions, reset values and sizes of the channel 0 resource registers.
`ifndef VCR0_CFG_SVH
`define VCR0_CFG_SVH

`define VCR0_ADDR_W 12
`define VCR0_OFF_CAP 12'h150
`define VCR0_OFF_CTRL 12'h154
`define VCR0_OFF_STAT 12'h158

`define VCR0_CAP_ARB_LO 0
`define VCR0_CAP_ARB_HI 7
`define VCR0_CAP_ARB_VAL 8'h09
`define VCR0_CAP_ADVSW_BIT 14
`define VCR0_CAP_SNOOP_BIT 15
`define VCR0_CAP_SLOTS_LO 16
`define VCR0_CAP_SLOTS_HI 22
`define VCR0_CAP_SLOTS_VAL 7'h7F
`define VCR0_CAP_TBL_LO 24
`define VCR0_CAP_TBL_HI 31
`define VCR0_CAP_TBL_VAL 8'h04

`define VCR0_CTRL_MAP_LO 0
`define VCR0_CTRL_MAP_HI 7
`define VCR0_CTRL_MAP_RST 8'hFF
`define VCR0_CTRL_LOAD_BIT 16
`define VCR0_CTRL_SEL_LO 17
`define VCR0_CTRL_SEL_HI 19
`define VCR0_CTRL_SEL_RST 3'h0
`define VCR0_CTRL_ID_LO 24
`define VCR0_CTRL_ID_HI 26
`define VCR0_CTRL_ID_VAL 3'h0
`define VCR0_CTRL_EN_BIT 31
`define VCR0_CTRL_EN_RST 1'h1

`define VCR0_STAT_TBL_BIT 16
`define VCR0_STAT_NEG_BIT 17

`define VCR0_SCHEME_DEFAULT 3'h0
`define VCR0_SCHEME_WEIGHTED 3'h3

`define VCR0_PHASES 128
`define VCR0_PHASE_W 7
`define VCR0_ENTRY_W 4
`define VCR0_LAST_PHASE 7'h7F

`endif

// file: design/vcr0_pkg.sv
// Types shared by the channel 0 resource register bank and its table loader.
`include "vcr0_cfg.svh"

package vcr0_pkg;

    typedef enum logic [1:0] {
        VCR0_LD_IDLE,
        VCR0_LD_COPY,
        VCR0_LD_DONE
    } vcr0_load_state_t;

    typedef logic [`VCR0_ENTRY_W-1:0] vcr0_entry_t;

    typedef struct packed {
        vcr0_load_state_t state;
        logic [`VCR0_PHASE_W-1:0] index;
        vcr0_entry_t [`VCR0_PHASES-1:0] entries;
        vcr0_entry_t activeEntry;
        logic loadDone;
    } vcr0_loader_state_t;

    typedef struct packed {
        logic [7:0] trafficClassChannelMap;
        logic [2:0] arbSelect;
        logic channelEnable;
        logic tableStatus;
        logic negotiationPending;
        logic loadStart;
        logic [31:0] prdata;
        logic pslverr;
    } vcr0_reg_state_t;

endpackage

// file: design/vcr0_table_loader.sv
// Copies the programmed port arbitration table into the active table used by the arbiter.
`timescale 1ns/1ps
`default_nettype none
`include "vcr0_cfg.svh"

module vcr0_table_loader
    import vcr0_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic loadStart,
    output logic [`VCR0_PHASE_W-1:0] tableRdAddr,
    input wire logic [`VCR0_ENTRY_W-1:0] tableRdData,
    input wire logic [`VCR0_PHASE_W-1:0] arbPhase,
    output logic [`VCR0_ENTRY_W-1:0] activeEntry,
    output logic busy,
    output logic loadDone
);

    vcr0_loader_state_t cur;
    vcr0_loader_state_t next_cur;

    // The programmed table is read combinationally at the walking index.
    assign tableRdAddr = cur.index;
    assign busy = (cur.state == VCR0_LD_COPY);
    assign activeEntry = cur.activeEntry;
    assign loadDone = cur.loadDone;

    always_comb
    begin
        next_cur = cur;
        next_cur.loadDone = 1'b0;
        // Arbiter lookup reads the active table, one entry of four bits per phase.
        next_cur.activeEntry = cur.entries[arbPhase]; // [RULE_16]
        case (cur.state)
            VCR0_LD_IDLE:
            begin
                if (loadStart)
                begin
                    next_cur.index = '0;
                    next_cur.state = VCR0_LD_COPY;
                end
            end
            VCR0_LD_COPY:
            begin
                next_cur.entries[cur.index] = tableRdData; // [RULE_16]
                next_cur.index = cur.index + 1'b1;
                if (cur.index == `VCR0_LAST_PHASE)
                begin
                    next_cur.state = VCR0_LD_DONE;
                end
            end
            VCR0_LD_DONE:
            begin
                next_cur.loadDone = 1'b1; // [RULE_14]
                next_cur.index = '0;
                next_cur.state = VCR0_LD_IDLE;
            end
            default:
            begin
                next_cur.state = VCR0_LD_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

endmodule
`default_nettype wire

// file: design/vcr0_resource_registers.sv
// APB register bank for the channel 0 resource: capability, control and status.
//
// Functional notes
// [RULE_01] Capability bits 7:0 read 09h: fixed round robin and 128-phase weighted round robin.
// [RULE_02] Time-based weighted round robin is never accepted on channel zero.
// [RULE_03] Capability bit 14, advanced switching only, reads zero.
// [RULE_04] Capability bit 15, snoop rejection, reads zero.
// [RULE_05] Capability bits 22:16 read maximum time slots minus one, 7Fh.
// [RULE_06] Capability bits 31:24 read table offset 04h in sixteen byte units.
// [RULE_07] Control bits 7:0 hold the traffic class map, reset FFh.
// [RULE_08] Serial management or autoload may replace the traffic class map default.
// [RULE_09] Writing one to control bit 16 loads the table; it reads zero.
// [RULE_10] Select field 19:17 accepts 000b or 011b; others act as default.
// [RULE_11] Control bits 26:24 read the channel identifier, 000b.
// [RULE_12] Control bit 31 enables channel zero, reset one.
// [RULE_13] Status bit 16 sets whenever software writes any table entry.
// [RULE_14] Status bit 16 clears when the hardware table load finishes.
// [RULE_15] Status bit 17 is set while negotiation is in progress.
// [RULE_16] Arbitration table entries are four bits wide.
// [RULE_17] Reserved fields read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "vcr0_cfg.svh"

module vcr0_resource_registers
    import vcr0_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`VCR0_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mapLoadValid,
    input wire logic [7:0] mapLoadValue,
    input wire logic tableEntryWritten,
    output logic [`VCR0_PHASE_W-1:0] tableRdAddr,
    input wire logic [`VCR0_ENTRY_W-1:0] tableRdData,
    input wire logic [`VCR0_PHASE_W-1:0] arbPhase,
    output logic [`VCR0_ENTRY_W-1:0] activeEntry,
    output logic tableLoading,
    input wire logic negotiationStart,
    input wire logic negotiationDone,
    output logic [7:0] trafficClassChannelMap,
    output logic [2:0] arbScheme,
    output logic channelEnable,
    output logic negotiationPending
);

    vcr0_reg_state_t cur;
    vcr0_reg_state_t next_cur;

    logic [31:0] writeMask;
    logic [31:0] maskedData;
    logic setupPhase;
    logic accessWrite;
    logic hitCap;
    logic hitCtrl;
    logic hitStat;
    logic mapped;
    logic loaderBusy;
    logic loaderDone;
    logic [31:0] capWord;
    logic [31:0] ctrlWord;
    logic [31:0] statWord;
    logic [2:0] writtenSelect;

    // Only the encodings valid on this channel pass; the rest select the default.
    function automatic logic [2:0] legal_scheme(input logic [2:0] sel);
        logic [2:0] result;
        result = `VCR0_SCHEME_DEFAULT;
        if (sel == `VCR0_SCHEME_WEIGHTED)
        begin
            result = `VCR0_SCHEME_WEIGHTED;
        end
        return result;
    endfunction

    // Byte strobes widen to a per-bit write mask.
    genvar bitIdx;
    generate
        for (bitIdx = 0; bitIdx < 32; bitIdx = bitIdx + 1)
        begin : g_mask
            assign writeMask[bitIdx] = pstrb[bitIdx / 8];
        end
    endgenerate

    assign maskedData = pwdata & writeMask;
    assign setupPhase = psel & ~penable;
    assign accessWrite = psel & penable & pwrite;
    assign hitCap = (paddr == `VCR0_OFF_CAP);
    assign hitCtrl = (paddr == `VCR0_OFF_CTRL);
    assign hitStat = (paddr == `VCR0_OFF_STAT);
    assign mapped = hitCap | hitCtrl | hitStat;

    // Capability word: constants only, reserved bits zero.
    always_comb
    begin
        capWord = '0;
        capWord[`VCR0_CAP_ARB_HI:`VCR0_CAP_ARB_LO] = `VCR0_CAP_ARB_VAL; // [RULE_01]
        capWord[`VCR0_CAP_ADVSW_BIT] = 1'b0; // [RULE_03]
        capWord[`VCR0_CAP_SNOOP_BIT] = 1'b0; // [RULE_04]
        capWord[`VCR0_CAP_SLOTS_HI:`VCR0_CAP_SLOTS_LO] = `VCR0_CAP_SLOTS_VAL; // [RULE_05]
        capWord[`VCR0_CAP_TBL_HI:`VCR0_CAP_TBL_LO] = `VCR0_CAP_TBL_VAL; // [RULE_06]
    end

    // Control word: the load bit always reads zero, reserved bits zero.
    always_comb
    begin
        ctrlWord = '0; // [RULE_17]
        ctrlWord[`VCR0_CTRL_MAP_HI:`VCR0_CTRL_MAP_LO] = cur.trafficClassChannelMap; // [RULE_07]
        ctrlWord[`VCR0_CTRL_LOAD_BIT] = 1'b0; // [RULE_09]
        ctrlWord[`VCR0_CTRL_SEL_HI:`VCR0_CTRL_SEL_LO] = cur.arbSelect;
        ctrlWord[`VCR0_CTRL_ID_HI:`VCR0_CTRL_ID_LO] = `VCR0_CTRL_ID_VAL; // [RULE_11]
        ctrlWord[`VCR0_CTRL_EN_BIT] = cur.channelEnable; // [RULE_12]
    end

    // Status word.
    always_comb
    begin
        statWord = '0; // [RULE_17]
        statWord[`VCR0_STAT_TBL_BIT] = cur.tableStatus;
        statWord[`VCR0_STAT_NEG_BIT] = cur.negotiationPending; // [RULE_15]
    end

    assign writtenSelect = maskedData[`VCR0_CTRL_SEL_HI:`VCR0_CTRL_SEL_LO];

    always_comb
    begin
        next_cur = cur;
        next_cur.loadStart = 1'b0;

        // Read data and error are captured in the setup cycle for the access cycle.
        if (setupPhase)
        begin
            next_cur.pslverr = ~mapped;
            if (pwrite | ~mapped)
            begin
                next_cur.prdata = '0;
            end
            else if (hitCap)
            begin
                next_cur.prdata = capWord;
            end
            else if (hitCtrl)
            begin
                next_cur.prdata = ctrlWord;
            end
            else
            begin
                next_cur.prdata = statWord;
            end
        end

        // A strap value from serial management or autoload replaces the map.
        if (mapLoadValid)
        begin
            next_cur.trafficClassChannelMap = mapLoadValue; // [RULE_08]
        end

        // Writes land at the access edge; capability and status are read-only.
        if (accessWrite & hitCtrl)
        begin
            if (pstrb[0])
            begin
                next_cur.trafficClassChannelMap =
                    maskedData[`VCR0_CTRL_MAP_HI:`VCR0_CTRL_MAP_LO]; // [RULE_07]
            end
            if (pstrb[2])
            begin
                // Anything other than 011b, time-based included, stores the default.
                next_cur.arbSelect = legal_scheme(writtenSelect); // [RULE_10] [RULE_02]
                if (maskedData[`VCR0_CTRL_LOAD_BIT] & ~loaderBusy)
                begin
                    next_cur.loadStart = 1'b1; // [RULE_09]
                end
            end
            if (pstrb[3])
            begin
                next_cur.channelEnable = maskedData[`VCR0_CTRL_EN_BIT]; // [RULE_12]
            end
        end

        // Table status: the finished load clears it, a new entry write wins.
        if (loaderDone)
        begin
            next_cur.tableStatus = 1'b0; // [RULE_14]
        end
        if (tableEntryWritten)
        begin
            next_cur.tableStatus = 1'b1; // [RULE_13]
        end

        // Negotiation pending: start wins over a completion in the same cycle.
        if (negotiationDone)
        begin
            next_cur.negotiationPending = 1'b0; // [RULE_15]
        end
        if (negotiationStart)
        begin
            next_cur.negotiationPending = 1'b1; // [RULE_15]
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cur.trafficClassChannelMap <= `VCR0_CTRL_MAP_RST;
            cur.arbSelect <= `VCR0_CTRL_SEL_RST;
            cur.channelEnable <= `VCR0_CTRL_EN_RST;
            cur.tableStatus <= 1'b0;
            cur.negotiationPending <= 1'b0;
            cur.loadStart <= 1'b0;
            cur.prdata <= '0;
            cur.pslverr <= 1'b0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    vcr0_table_loader u_loader (
        .core_clk(core_clk),
        .rst(rst),
        .loadStart(cur.loadStart),
        .tableRdAddr(tableRdAddr),
        .tableRdData(tableRdData),
        .arbPhase(arbPhase),
        .activeEntry(activeEntry),
        .busy(loaderBusy),
        .loadDone(loaderDone)
    );

    // Access cycle always completes in one cycle; data was prepared in setup.
    assign pready = 1'b1;
    assign prdata = cur.prdata;
    assign pslverr = cur.pslverr & psel & penable;
    assign trafficClassChannelMap = cur.trafficClassChannelMap;
    assign arbScheme = cur.arbSelect;
    assign channelEnable = cur.channelEnable;
    assign negotiationPending = cur.negotiationPending;
    assign tableLoading = loaderBusy | cur.loadStart;

endmodule
`default_nettype wire

// file: sim/vcr0_props.sv
// Concurrent checks on the ports of the channel 0 resource register bank.
`timescale 1ns/1ps
`default_nettype none
module vcr0_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic mapLoadValid,
    input wire logic [7:0] mapLoadValue,
    input wire logic tableLoading,
    input wire logic negotiationStart,
    input wire logic negotiationDone,
    input wire logic [7:0] trafficClassChannelMap,
    input wire logic [2:0] arbScheme,
    input wire logic channelEnable,
    input wire logic negotiationPending
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic acc;
    logic ctlWr;
    int unsigned loadRun;
    assign acc = psel && penable;
    assign ctlWr = acc && pwrite && paddr == 12'h154;
    // Counts the cycles of one load: the start cycle plus one per table entry.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            loadRun <= 0;
        else if (tableLoading)
            loadRun <= loadRun + 1;
        else
            loadRun <= 0;
    end
    a_cap_value: assert property (acc && !pwrite && paddr == 12'h150 |->
        prdata == 32'h047F0009) else $error("capability word wrong");
    a_ctl_fixed: assert property (acc && !pwrite && paddr == 12'h154 |->
        (prdata & 32'h7FF1FF00) == 32'h0) else $error("control fixed bits not zero");
    a_sched_legal: assert property (arbScheme == 3'h0 || arbScheme == 3'h3)
        else $error("illegal arbitration scheme");
    a_map_write: assert property (ctlWr && pstrb[0] |=>
        trafficClassChannelMap == $past(pwdata[7:0])) else $error("map write lost");
    a_enable_write: assert property (ctlWr && pstrb[3] |=>
        channelEnable == $past(pwdata[31])) else $error("enable write lost");
    a_map_load: assert property (mapLoadValid && !(ctlWr && pstrb[0]) |=>
        trafficClassChannelMap == $past(mapLoadValue)) else $error("map load lost");
    a_neg_set: assert property (negotiationStart |=> negotiationPending)
        else $error("pending not set");
    a_neg_clear: assert property (negotiationDone && !negotiationStart |=>
        !negotiationPending) else $error("pending not cleared");
    a_load_start: assert property (ctlWr && pstrb[2] && pwdata[16] && !tableLoading
        |=> tableLoading) else $error("load did not start");
    a_load_span: assert property ($fell(tableLoading) |-> loadRun == 129)
        else $error("load length wrong");
    a_bad_addr: assert property (acc && paddr != 12'h150 && paddr != 12'h154
        && paddr != 12'h158 |-> pslverr && prdata == 32'h0) else $error("unmapped access");
    cover property (ctlWr && pwdata[16]);
    cover property (negotiationStart);
    cover property (mapLoadValid);
endmodule
`default_nettype wire

// file: sim/vcr0_testbench.sv
// Self-checking bench for the channel 0 resource register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk = 0;
    logic rst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [31:0] d;
    logic [3:0] pstrb = 0;
    logic [3:0] pulses = 0;
    logic [3:0] tableRdData;
    logic [3:0] activeEntry;
    logic [3:0] tbl [128];
    logic pready, pslverr, err, tableLoading, channelEnable, negotiationPending;
    logic [7:0] mapLoadValue = 0;
    logic [7:0] trafficClassChannelMap;
    logic [6:0] tableRdAddr;
    logic [6:0] arbPhase = 0;
    logic [2:0] arbScheme;
    int mismatches = 0, samples_checked = 0, seed = 23;
    int mMap = 255, mSel = 0, mEn = 1, n;
    always #12.5 core_clk = ~core_clk;
    assign tableRdData = tbl[tableRdAddr];
    vcr0_resource_registers vcr0_resource_registers_i (.core_clk, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .mapLoadValid(pulses[0]), .mapLoadValue, .tableEntryWritten(pulses[1]),
        .tableRdAddr, .tableRdData, .arbPhase, .activeEntry, .tableLoading,
        .negotiationStart(pulses[2]), .negotiationDone(pulses[3]),
        .trafficClassChannelMap, .arbScheme, .channelEnable, .negotiationPending);
    task automatic final_report;
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
        input logic [3:0] s);
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    function automatic logic [31:0] ctl();
        return 32'((mEn << 31) | (mSel << 17) | mMap);
    endfunction
    task automatic wr(input logic [31:0] v, input logic [3:0] s);
        apb(1, 12'h154, v, s);
        if (s[0]) mMap = v[7:0];
        if (s[2]) mSel = (v[19:17] == 3'h3) ? 3 : 0;
        if (s[3]) mEn = v[31];
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 32'($random(seed)), 4'hF);
        chk(rd, exp);
    endtask
    task automatic pulse(input int k);
        @(posedge core_clk);
        pulses[k] <= 1;
        @(posedge core_clk);
        pulses <= 0;
    endtask
    initial
    begin
        for (int i = 0; i < 128; i++) tbl[i] = 4'($random(seed));
        repeat (2) @(posedge core_clk);
        rst <= 0;
        rdchk(12'h150, 32'h047F0009);
        rdchk(12'h154, 32'h800000FF);
        apb(1, 12'h150, '1, 4'hF);
        apb(1, 12'h158, '1, 4'hF);
        rdchk(12'h150, 32'h047F0009);
        rdchk(12'h158, 32'h0);
        for (int i = 0; i < 24; i++)
        begin
            d = 32'($random(seed)) & ~32'h10000;
            if (i < 8) d[19:17] = 3'(i);
            wr(d, (i < 8) ? 4'hF : 4'($random(seed)));
            rdchk(12'h154, ctl());
            d = 32'({3'(mSel), 1'(mEn), 8'(mMap)});
            chk(32'({arbScheme, channelEnable, trafficClassChannelMap}), d);
        end
        d = 32'($random(seed));
        mapLoadValue <= d[7:0];
        mMap = d[7:0];
        pulse(0);
        rdchk(12'h154, ctl());
        pulse(1);
        rdchk(12'h158, 32'h10000);
        wr(32'(32'h10000 | (mSel << 17)), 4'h4);
        rdchk(12'h154, ctl());
        for (n = 0; n < 400 && tableLoading; n++) @(posedge core_clk);
        chk(32'(tableLoading), 32'h0);
        rdchk(12'h158, 32'h0);
        for (int p = 0; p < 128; p += 37)
        begin
            arbPhase <= 7'(p);
            repeat (3) @(posedge core_clk);
            chk(32'(activeEntry), 32'(tbl[p]));
        end
        pulse(2);
        rdchk(12'h158, 32'h20000);
        pulse(3);
        rdchk(12'h158, 32'h0);
        apb(0, 12'h15C, 32'h0, 4'hF);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        final_report;
    end
    initial
    begin
        #200000;
        mismatches++;
        final_report;
    end
endmodule
bind vcr0_resource_registers vcr0_props vcr0_props_i (.core_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr, .mapLoadValid, .mapLoadValue,
    .tableLoading, .negotiationStart, .negotiationDone, .trafficClassChannelMap,
    .arbScheme, .channelEnable, .negotiationPending);
`default_nettype wire
